/* File: common/rls_pkg.sv */
`default_nettype none
package rls_pkg;
    // register map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [11:0] REG_CTRL = 12'h100;
    localparam logic [11:0] REG_STATUS = 12'h104;
    localparam logic [11:0] REG_PKT_COUNT = 12'h108;
    localparam logic [11:0] REG_RX_GOOD = 12'h10c;
    localparam logic [11:0] REG_RX_BAD = 12'h110;
    localparam logic [11:0] REG_USER = 12'h114;
    localparam logic [11:0] REG_TRIGGER = 12'h13c;
    // field positions
    localparam int CTRL_DUPLEX_BIT = 0;
    localparam int CTRL_GEN_START_BIT = 1;
    localparam int CTRL_TARGET_40G_BIT = 2;
    localparam int TRIGGER_BIT = 0;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_SPEED_40G_BIT = 1;
    localparam int ST_ANLT_DONE_BIT = 2;
    localparam int ST_GEN_BUSY_BIT = 3;
    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PKT_COUNT_RST = 32'h0000_0010;
    localparam logic [31:0] USER_RST = 32'h0000_0000;
    localparam logic SPEED_40G_RST = 1'b0;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // rate select encoding
    localparam logic RATE_40G = 1'b1;
    localparam logic RATE_50G = 1'b0;
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int XCVR_RST_NS = 1000;
    localparam int CORE_RST_NS = 2000;
    localparam int XCVR_RST_CYC = (XCVR_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CORE_RST_CYC = (CORE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REQ_MIN_CYC = 2;
    localparam int SYNC_STAGES = 3;
    // transceiver channel write list, channel addresses only
    localparam int CFG_ADDR_W = 10;
    localparam int CFG_DATA_W = 16;
    localparam int NUM_CHAN_WRITES = 4;
    localparam logic [9:0] CHAN_ADDR [NUM_CHAN_WRITES] = '{10'h00c, 10'h028, 10'h063, 10'h07a};
    localparam logic [15:0] CHAN_DATA_40G [NUM_CHAN_WRITES] =
        '{16'h0010, 16'h0101, 16'h8000, 16'h0022};
    localparam logic [15:0] CHAN_DATA_50G [NUM_CHAN_WRITES] =
        '{16'h0020, 16'h0100, 16'h0000, 16'h0021};

    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_WRITE, SEQ_WAIT_DONE, SEQ_XCVR_RST, SEQ_CORE_RST
    } rls_seq_state_t;
    typedef enum logic [1:0] {WR_IDLE, WR_ISSUE, WR_WAIT} rls_wr_state_t;
endpackage
`default_nettype wire

/* File: common/rls_cfg_if.sv */
`default_nettype none
interface rls_cfg_if;
    logic start;
    logic target_40g;
    logic busy;
    logic done;
    modport seq (output start, output target_40g, input busy, input done);
    modport writer (input start, input target_40g, output busy, output done);
endinterface
`default_nettype wire

/* File: design/rls_chan_writer.sv */
`default_nettype none
module rls_chan_writer (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // sequencer side
    rls_cfg_if.writer ctl,
    // transceiver channel configuration port
    output logic cfg_en_o,
    output logic cfg_we_o,
    output logic [rls_pkg::CFG_ADDR_W-1:0] cfg_addr_o,
    output logic [rls_pkg::CFG_DATA_W-1:0] cfg_data_o,
    input wire logic cfg_rdy_i
);
    rls_pkg::rls_wr_state_t state;
    logic [1:0] idx;
    logic to_40g;

    assign ctl.busy = (state != rls_pkg::WR_IDLE);

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state <= rls_pkg::WR_IDLE;
            idx <= 2'h0;
            to_40g <= 1'b0;
            ctl.done <= 1'b0;
        end else if (ce_i) begin
            ctl.done <= 1'b0;
            case (state)
                rls_pkg::WR_IDLE: begin
                    if (ctl.start) begin
                        idx <= 2'h0;
                        to_40g <= ctl.target_40g;
                        state <= rls_pkg::WR_ISSUE;
                    end
                end
                rls_pkg::WR_ISSUE: state <= rls_pkg::WR_WAIT;
                rls_pkg::WR_WAIT: begin
                    if (cfg_rdy_i) begin
                        if (idx == 2'(rls_pkg::NUM_CHAN_WRITES - 1)) begin
                            ctl.done <= 1'b1;
                            state <= rls_pkg::WR_IDLE;
                        end else begin
                            idx <= idx + 2'h1;
                            state <= rls_pkg::WR_ISSUE;
                        end
                    end
                end
                default: state <= rls_pkg::WR_IDLE;
            endcase
        end
    end

    // only channel addresses listed; plls untouched
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cfg_en_o <= 1'b0;
            cfg_we_o <= 1'b0;
            cfg_addr_o <= '0;
            cfg_data_o <= '0;
        end else if (ce_i) begin
            cfg_en_o <= (state == rls_pkg::WR_ISSUE);
            cfg_we_o <= (state == rls_pkg::WR_ISSUE);
            if (state == rls_pkg::WR_ISSUE) begin
                cfg_addr_o <= rls_pkg::CHAN_ADDR[idx];
                cfg_data_o <= to_40g ? rls_pkg::CHAN_DATA_40G[idx] : rls_pkg::CHAN_DATA_50G[idx];
            end
        end
    end
endmodule // rls_chan_writer
`default_nettype wire

/* File: design/rls_switcher.sv */
// Summary of operation
// - rate select value one means 40G, zero means 50G.
// - with negotiation logic present, output flags negotiation and training complete.
// - writing one to 0x013C starts reprogramming and pulses the rate switch output.
// - valid request writes that core's transceiver channel, then resets the core.
// - writes touch only the channel; both shared plls stay fixed per rate.
// - rate change accepted only while the sequencer is idle, either direction; requests during a switch are dropped.
// - duplex test mode: transmitter and receiver active, transceiver output looped back.
// - generator sends requested packet count; monitor checks received packets.
// - user output mirrors the user register.
// - reprogram done input marks writes complete and triggers transceiver reset.
`default_nettype none
module rls_switcher #(
    parameter bit INCLUDE_ANLT = 1'b1,
    parameter int DATA_W = 64,
    parameter int PKT_WORDS = 8
) (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // register bus
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external pins
    input wire logic rate_change_req_i,
    input wire logic rate_mode_i,
    input wire logic reprogram_done_i,
    input wire logic anlt_complete_i,
    // transceiver channel configuration port
    output logic cfg_en_o,
    output logic cfg_we_o,
    output logic [rls_pkg::CFG_ADDR_W-1:0] cfg_addr_o,
    output logic [rls_pkg::CFG_DATA_W-1:0] cfg_data_o,
    input wire logic cfg_rdy_i,
    // resets and status
    output logic xcvr_reset_o,
    output logic core_reset_o,
    output logic rate_switch_o,
    output logic speed_40g_o,
    output logic anlt_done_o,
    output logic [31:0] user_defined_output_o,
    output logic loopback_o,
    // test data path
    output logic tx_valid_o,
    output logic [DATA_W-1:0] tx_data_o,
    output logic tx_last_o,
    input wire logic tx_ready_i,
    input wire logic rx_valid_i,
    input wire logic [DATA_W-1:0] rx_data_i,
    input wire logic rx_last_i
);
    localparam int NPIN = 4;
    rls_cfg_if cfg ();
    rls_pkg::rls_seq_state_t state;

    logic [31:0] ctrl, pkt_count, rx_good, rx_bad, user_reg;
    logic [NPIN-1:0] sync0, sync1, sync2, pin_f;
    logic req_f_d, done_f_d, done_seen, target_40g;
    logic [2:0] req_cnt;
    logic [7:0] rst_cnt;
    logic wr_fire, trig_wr, start_seq, req_valid;
    logic [31:0] wmask;
    logic [31:0] pkts_left;
    logic [15:0] tx_idx, rx_idx;
    logic rx_pkt_err, gen_busy;

    // level moves only when stages two and three agree
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sync0 <= '0;
            sync1 <= '0;
            sync2 <= '0;
            pin_f <= '0;
        end else if (ce_i) begin
            sync0 <= {anlt_complete_i, reprogram_done_i, rate_mode_i, rate_change_req_i};
            sync1 <= sync0;
            sync2 <= sync1;
            for (int i = 0; i < NPIN; i++) begin
                if (sync1[i] == sync2[i]) pin_f[i] <= sync2[i];
            end
        end
    end

    // request is high at least two cycles, acted on at its fall
    assign req_valid = req_f_d && !pin_f[0] && (req_cnt >= 3'(rls_pkg::REQ_MIN_CYC));
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            req_f_d <= 1'b0;
            req_cnt <= 3'h0;
        end else if (ce_i) begin
            req_f_d <= pin_f[0];
            if (!pin_f[0]) req_cnt <= 3'h0;
            else if (req_cnt != 3'h7) req_cnt <= req_cnt + 3'h1;
        end
    end

    // register bus writes
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign trig_wr = wr_fire && (s_axi_awaddr[11:0] == rls_pkg::REG_TRIGGER)
                     && s_axi_wstrb[0] && s_axi_wdata[rls_pkg::TRIGGER_BIT];
    // busy sequencer drops new starts
    assign start_seq = (state == rls_pkg::SEQ_IDLE) && (trig_wr || req_valid);

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ctrl <= rls_pkg::CTRL_RST;
            pkt_count <= rls_pkg::PKT_COUNT_RST;
            user_reg <= rls_pkg::USER_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rls_pkg::RESP_OKAY;
        end else if (ce_i) begin
            // generator start is a one-shot bit
            ctrl[rls_pkg::CTRL_GEN_START_BIT] <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= rls_pkg::RESP_OKAY;
                case (s_axi_awaddr[11:0])
                    rls_pkg::REG_CTRL: ctrl <= (ctrl & ~wmask) | (s_axi_wdata & wmask);
                    rls_pkg::REG_PKT_COUNT:
                        pkt_count <= (pkt_count & ~wmask) | (s_axi_wdata & wmask);
                    rls_pkg::REG_USER: user_reg <= (user_reg & ~wmask) | (s_axi_wdata & wmask);
                    rls_pkg::REG_TRIGGER, rls_pkg::REG_STATUS,
                    rls_pkg::REG_RX_GOOD, rls_pkg::REG_RX_BAD: ;
                    default: s_axi_bresp <= rls_pkg::RESP_DECERR;
                endcase
            end
        end
    end

    // register bus reads
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rls_pkg::RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rls_pkg::RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                case (s_axi_araddr[11:0])
                    rls_pkg::REG_CTRL: s_axi_rdata <= ctrl;
                    rls_pkg::REG_STATUS: begin
                        s_axi_rdata[rls_pkg::ST_BUSY_BIT] <= (state != rls_pkg::SEQ_IDLE);
                        s_axi_rdata[rls_pkg::ST_SPEED_40G_BIT] <= speed_40g_o;
                        s_axi_rdata[rls_pkg::ST_ANLT_DONE_BIT] <= anlt_done_o;
                        s_axi_rdata[rls_pkg::ST_GEN_BUSY_BIT] <= gen_busy;
                    end
                    rls_pkg::REG_PKT_COUNT: s_axi_rdata <= pkt_count;
                    rls_pkg::REG_RX_GOOD: s_axi_rdata <= rx_good;
                    rls_pkg::REG_RX_BAD: s_axi_rdata <= rx_bad;
                    rls_pkg::REG_USER: s_axi_rdata <= user_reg;
                    // trigger is self-clearing and always reads zero
                    rls_pkg::REG_TRIGGER: ;
                    default: s_axi_rresp <= rls_pkg::RESP_DECERR;
                endcase
            end
        end
    end

    // channel writes, done, transceiver reset, core reset
    assign cfg.start = start_seq;
    assign cfg.target_40g = trig_wr ? ctrl[rls_pkg::CTRL_TARGET_40G_BIT] : pin_f[1];

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state <= rls_pkg::SEQ_IDLE;
            rst_cnt <= 8'h00;
            done_f_d <= 1'b0;
            done_seen <= 1'b0;
            target_40g <= rls_pkg::SPEED_40G_RST;
            speed_40g_o <= rls_pkg::SPEED_40G_RST;
            rate_switch_o <= 1'b0;
            xcvr_reset_o <= 1'b0;
            core_reset_o <= 1'b0;
        end else if (ce_i) begin
            done_f_d <= pin_f[2];
            rate_switch_o <= start_seq && trig_wr;
            // a stale high done level must not end a fresh sequence
            if (pin_f[2] && !done_f_d && state != rls_pkg::SEQ_IDLE) done_seen <= 1'b1;
            case (state)
                rls_pkg::SEQ_IDLE: begin
                    done_seen <= 1'b0;
                    if (start_seq) begin
                        target_40g <= cfg.target_40g;
                        state <= rls_pkg::SEQ_WRITE;
                    end
                end
                rls_pkg::SEQ_WRITE: if (cfg.done) state <= rls_pkg::SEQ_WAIT_DONE;
                rls_pkg::SEQ_WAIT_DONE: begin
                    if (done_seen) begin
                        xcvr_reset_o <= 1'b1;
                        rst_cnt <= 8'(rls_pkg::XCVR_RST_CYC - 1);
                        state <= rls_pkg::SEQ_XCVR_RST;
                    end
                end
                rls_pkg::SEQ_XCVR_RST: begin
                    if (rst_cnt == 8'h00) begin
                        xcvr_reset_o <= 1'b0;
                        core_reset_o <= 1'b1;
                        rst_cnt <= 8'(rls_pkg::CORE_RST_CYC - 1);
                        state <= rls_pkg::SEQ_CORE_RST;
                    end else begin
                        rst_cnt <= rst_cnt - 8'h01;
                    end
                end
                rls_pkg::SEQ_CORE_RST: begin
                    if (rst_cnt == 8'h00) begin
                        core_reset_o <= 1'b0;
                        speed_40g_o <= target_40g;
                        state <= rls_pkg::SEQ_IDLE;
                    end else begin
                        rst_cnt <= rst_cnt - 8'h01;
                    end
                end
                default: state <= rls_pkg::SEQ_IDLE;
            endcase
        end
    end

    rls_chan_writer u_writer (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .ce_i(ce_i),
        .ctl(cfg.writer),
        .cfg_en_o(cfg_en_o),
        .cfg_we_o(cfg_we_o),
        .cfg_addr_o(cfg_addr_o),
        .cfg_data_o(cfg_data_o),
        .cfg_rdy_i(cfg_rdy_i)
    );

    // status and mirror outputs
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            anlt_done_o <= 1'b0;
            user_defined_output_o <= rls_pkg::USER_RST;
            loopback_o <= 1'b0;
        end else if (ce_i) begin
            anlt_done_o <= INCLUDE_ANLT && pin_f[3];
            user_defined_output_o <= user_reg;
            loopback_o <= ctrl[rls_pkg::CTRL_DUPLEX_BIT];
        end
    end

    // packet generator; pauses while the core is being switched
    assign gen_busy = (pkts_left != 32'h0);
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pkts_left <= 32'h0;
            tx_idx <= 16'h0;
            tx_valid_o <= 1'b0;
            tx_data_o <= '0;
            tx_last_o <= 1'b0;
        end else if (ce_i) begin
            if (tx_valid_o && tx_ready_i) begin
                tx_valid_o <= 1'b0;
                if (tx_last_o) begin
                    pkts_left <= pkts_left - 32'h1;
                    tx_idx <= 16'h0;
                end else begin
                    tx_idx <= tx_idx + 16'h1;
                end
            end else if (!tx_valid_o && gen_busy && state == rls_pkg::SEQ_IDLE) begin
                tx_valid_o <= 1'b1;
                tx_data_o <= DATA_W'(tx_idx);
                tx_last_o <= (tx_idx == 16'(PKT_WORDS - 1));
            end
            if (!gen_busy && ctrl[rls_pkg::CTRL_GEN_START_BIT]
                && ctrl[rls_pkg::CTRL_DUPLEX_BIT]) begin
                pkts_left <= pkt_count;
            end
        end
    end

    // monitor: words count up from zero, last on the final word
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rx_idx <= 16'h0;
            rx_pkt_err <= 1'b0;
            rx_good <= 32'h0;
            rx_bad <= 32'h0;
        end else if (ce_i) begin
            if (ctrl[rls_pkg::CTRL_GEN_START_BIT] && !gen_busy) begin
                rx_good <= 32'h0;
                rx_bad <= 32'h0;
            end else if (rx_valid_i) begin
                if (rx_last_i) begin
                    rx_idx <= 16'h0;
                    rx_pkt_err <= 1'b0;
                    if (rx_pkt_err || rx_data_i != DATA_W'(rx_idx)
                        || rx_idx != 16'(PKT_WORDS - 1)) begin
                        rx_bad <= rx_bad + 32'h1;
                    end else begin
                        rx_good <= rx_good + 32'h1;
                    end
                end else begin
                    rx_idx <= rx_idx + 16'h1;
                    if (rx_data_i != DATA_W'(rx_idx)) rx_pkt_err <= 1'b1;
                end
            end
        end
    end
endmodule // rls_switcher
`default_nettype wire

/* File: verif/rls_monitor.sv */
`default_nettype none
module rls_monitor (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // watched ports
    input wire logic anlt_complete_i,
    input wire logic cfg_en_o,
    input wire logic cfg_we_o,
    input wire logic [rls_pkg::CFG_ADDR_W-1:0] cfg_addr_o,
    input wire logic xcvr_reset_o,
    input wire logic core_reset_o,
    input wire logic rate_switch_o,
    input wire logic speed_40g_o,
    input wire logic anlt_done_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    logic [7:0] xr_cnt, cr_cnt;
    logic [2:0] wr_cnt;
    always_ff @(posedge clock_i) begin
        xr_cnt <= (sys_rst_i || !xcvr_reset_o) ? 8'h00 : xr_cnt + 8'h01;
        cr_cnt <= (sys_rst_i || !core_reset_o) ? 8'h00 : cr_cnt + 8'h01;
        wr_cnt <= (sys_rst_i || core_reset_o) ? 3'h0 : wr_cnt + 3'(cfg_en_o);
    end
    sequence s_start;
        rate_switch_o ##1 (cfg_en_o && !rate_switch_o);
    endsequence
    property p_start; rate_switch_o |-> s_start; endproperty
    a_start: assert property (p_start) else $error("no write after start");
    property p_we; cfg_en_o |-> cfg_we_o && cfg_addr_o inside {rls_pkg::CHAN_ADDR}; endproperty
    a_we: assert property (p_we) else $error("bad write");
    property p_busy; cfg_en_o |-> wr_cnt < 3'h4; endproperty
    a_busy: assert property (p_busy) else $error("extra write");
    property p_xr_after; $rose(xcvr_reset_o) |-> wr_cnt == 3'h4; endproperty
    a_xr_after: assert property (p_xr_after) else $error("early reset");
    property p_xr_len; $fell(xcvr_reset_o) |-> xr_cnt == 8'd20 ##[0:1] core_reset_o; endproperty
    a_xr_len: assert property (p_xr_len) else $error("xcvr reset length");
    property p_cr_len; $fell(core_reset_o) |-> cr_cnt == 8'd40; endproperty
    a_cr_len: assert property (p_cr_len) else $error("core reset length");
    property p_speed; $changed(speed_40g_o) |-> $past(core_reset_o) || $past(core_reset_o, 2);
    endproperty
    a_speed: assert property (p_speed) else $error("stray speed change");
    property p_anlt_on; anlt_complete_i [*8] |-> anlt_done_o; endproperty
    a_anlt_on: assert property (p_anlt_on) else $error("done missing");
    property p_anlt_off; !anlt_complete_i [*8] |-> !anlt_done_o; endproperty
    a_anlt_off: assert property (p_anlt_off) else $error("done stuck");
endmodule // rls_monitor
bind rls_switcher rls_monitor rls_monitor_inst (.clock_i, .sys_rst_i, .anlt_complete_i, .cfg_en_o,
    .cfg_we_o, .cfg_addr_o, .xcvr_reset_o, .core_reset_o, .rate_switch_o, .speed_40g_o,
    .anlt_done_o);
`default_nettype wire

/* File: verif/rls_xcvr_model.sv */
`default_nettype none
module rls_xcvr_model (
    // clock
    input wire logic clock_i,
    // channel configuration port
    input wire logic cfg_en_i,
    output logic cfg_rdy_o,
    output logic reprogram_done_o,
    // data path
    input wire logic loopback_i,
    input wire logic tx_valid_i,
    input wire logic [63:0] tx_data_i,
    input wire logic tx_last_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [63:0] rx_data_o,
    output logic rx_last_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] wait_cnt = 2'h0, acks = 2'h0;
    logic pend = 1'b0, slow = 1'b0;
    initial begin
        {cfg_rdy_o, reprogram_done_o, tx_ready_o, rx_valid_o, rx_last_o} = 5'h00;
        rx_data_o = 64'h0;
    end
    // acks alternate prompt and slow
    always @(posedge clock_i) begin
        cfg_rdy_o <= 1'b0;
        tx_ready_o <= ~tx_ready_o;
        if (cfg_en_i) begin
            pend <= 1'b1;
            wait_cnt <= slow ? 2'h3 : 2'h0;
            slow <= ~slow;
            reprogram_done_o <= 1'b0;
        end else if (pend && wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end else if (pend) begin
            pend <= 1'b0;
            cfg_rdy_o <= 1'b1;
            acks <= acks + 2'h1;
            reprogram_done_o <= (acks == 2'h3);
        end
        // idle data inverts the previous output every cycle
        rx_valid_o <= loopback_i && tx_valid_i && tx_ready_o;
        rx_last_o <= tx_last_i;
        rx_data_o <= (loopback_i && tx_valid_i && tx_ready_o) ? tx_data_i : ~rx_data_o;
    end
endmodule // rls_xcvr_model
`default_nettype wire

/* File: verif/tb_rls_switcher.sv */
`default_nettype none
module tb_rls_switcher;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, rate_change_req_i = 0, rate_mode_i = 0, anlt_complete_i = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic reprogram_done_i, cfg_en_o, cfg_we_o, cfg_rdy_i, xcvr_reset_o, core_reset_o;
    logic rate_switch_o, speed_40g_o, anlt_done_o, loopback_o, tx_valid_o, tx_last_o;
    logic tx_ready_i, rx_valid_i, rx_last_i;
    logic [9:0] cfg_addr_o;
    logic [15:0] cfg_data_o;
    logic [31:0] user_defined_output_o;
    logic [63:0] tx_data_o, rx_data_i;
    int fail_count = 0;
    int tests_run = 0;
    int wr_idx = 0;
    int pulses = 0;
    logic exp_40g = 1'b1;
    rls_switcher rls_switcher_inst (.*);
    rls_xcvr_model rls_xcvr_model_inst (.clock_i, .cfg_en_i(cfg_en_o), .cfg_rdy_o(cfg_rdy_i),
        .reprogram_done_o(reprogram_done_i), .loopback_i(loopback_o), .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i),
        .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i), .rx_last_o(rx_last_i));
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr = {20'h0, a};
        s_axi_wdata = d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b111;
        do @(negedge clock_i); while (!s_axi_bvalid);
        {s_axi_awvalid, s_axi_wvalid} = 2'b00;
        check("bresp", 32'(s_axi_bresp), 32'(er));
        @(negedge clock_i);
        s_axi_bready = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er);
        s_axi_araddr = {20'h0, a};
        {s_axi_arvalid, s_axi_rready} = 2'b11;
        do @(negedge clock_i); while (!s_axi_rvalid);
        s_axi_arvalid = 1'b0;
        d = s_axi_rdata;
        check("rresp", 32'(s_axi_rresp), 32'(er));
        @(negedge clock_i);
        s_axi_rready = 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, d, rls_pkg::RESP_OKAY);
        check(what, d, exp);
    endtask
    task automatic pin_req(input logic mode);
        rate_mode_i = mode;
        rate_change_req_i = 1'b1;
        repeat (2) @(negedge clock_i);
        rate_change_req_i = 1'b0;
    endtask
    task automatic wait_speed(input logic v);
        for (int n = 0; n < 600 && speed_40g_o !== v; n++) @(negedge clock_i);
    endtask
    always @(negedge clock_i) begin
        if (rate_switch_o) pulses++;
        if (cfg_en_o) begin
            check("cfg_addr", 32'(cfg_addr_o), 32'(rls_pkg::CHAN_ADDR[wr_idx%4]));
            check("cfg_data", 32'(cfg_data_o), 32'(exp_40g ?
                rls_pkg::CHAN_DATA_40G[wr_idx%4] : rls_pkg::CHAN_DATA_50G[wr_idx%4]));
            wr_idx++;
        end
    end
    task automatic t_regs();
        logic [31:0] d;
        rd_chk(rls_pkg::REG_CTRL, rls_pkg::CTRL_RST, "ctrl");
        rd_chk(rls_pkg::REG_PKT_COUNT, rls_pkg::PKT_COUNT_RST, "pkt_count");
        rd_chk(rls_pkg::REG_USER, rls_pkg::USER_RST, "user");
        rd_chk(rls_pkg::REG_TRIGGER, 32'h0, "trigger");
        rd_chk(rls_pkg::REG_STATUS, 32'h0, "status");
        rd(12'h200, d, rls_pkg::RESP_DECERR);
        wr(12'h204, 32'hffff_ffff, rls_pkg::RESP_DECERR);
    endtask
    task automatic t_user_anlt();
        wr(rls_pkg::REG_USER, 32'h5a3c_96e1, rls_pkg::RESP_OKAY);
        repeat (2) @(negedge clock_i);
        check("user_out", user_defined_output_o, 32'h5a3c_96e1);
        anlt_complete_i = 1'b1;
        repeat (10) @(negedge clock_i);
        check("anlt_done", 32'(anlt_done_o), 32'h1);
        anlt_complete_i = 1'b0;
        repeat (10) @(negedge clock_i);
        check("anlt_idle", 32'(anlt_done_o), 32'h0);
    endtask
    task automatic t_switch();
        wr(rls_pkg::REG_CTRL, 32'h4, rls_pkg::RESP_OKAY);
        wr(rls_pkg::REG_TRIGGER, 32'h1, rls_pkg::RESP_OKAY);
        repeat (4) @(negedge clock_i);
        pin_req(rls_pkg::RATE_50G);
        wait_speed(1'b1);
        repeat (30) @(negedge clock_i);
        check("speed_40g", 32'(speed_40g_o), 32'h1);
        check("writes", wr_idx, 4);
        check("switch_pulses", pulses, 1);
        rd_chk(rls_pkg::REG_STATUS, 32'h2, "status_40g");
        exp_40g = 1'b0;
        pin_req(rls_pkg::RATE_50G);
        wait_speed(1'b0);
        check("speed_50g", 32'(speed_40g_o), 32'h0);
        check("writes_2", wr_idx, 8);
        check("switch_pulses_2", pulses, 1);
    endtask
    task automatic t_duplex();
        logic [31:0] d;
        int n;
        wr(rls_pkg::REG_PKT_COUNT, 32'h2, rls_pkg::RESP_OKAY);
        wr(rls_pkg::REG_CTRL, 32'h3, rls_pkg::RESP_OKAY);
        check("loopback", 32'(loopback_o), 32'h1);
        d = 32'h8;
        for (n = 0; n < 200 && d[rls_pkg::ST_GEN_BUSY_BIT]; n++) rd(rls_pkg::REG_STATUS, d, 2'h0);
        rd_chk(rls_pkg::REG_RX_GOOD, 32'h2, "rx_good");
        rd_chk(rls_pkg::REG_RX_BAD, 32'h0, "rx_bad");
    endtask
    initial begin
        repeat (20) @(negedge clock_i);
        sys_rst_i = 1'b0;
        @(negedge clock_i);
        t_regs();
        t_user_anlt();
        t_switch();
        t_duplex();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        fail_count++;
        report_and_stop();
    end
endmodule // tb_rls_switcher
`default_nettype wire
